// ### hdl/muldiv_logic_opcode_decode.sv
`default_nettype none
module muldiv_logic_opcode_decode (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_ce,
    // Instruction byte stream
    input  wire logic                 i_byte_valid,
    input  wire logic [7:0]           i_byte,
    // Decoded instruction
    output logic                      o_dec_valid,
    output opdec_pkg::decoded_t       o_dec
);
    opdec_pkg::state_t   state_reg, state_next;
    opdec_pkg::decoded_t cur_reg, cur_next;
    opdec_pkg::decoded_t out_reg, out_next;
    logic                out_valid_reg, out_valid_next;
    logic                imm_word_reg, imm_word_next;
    logic                need_imm_reg, need_imm_next;
    logic [7:0]          opc_reg, opc_next;

    function automatic logic [7:0] pick(input logic c, input logic [7:0] a, input logic [7:0] b);
        pick = c ? a : b;
    endfunction

    // Sets op and cycle window once the ModRM byte is known
    function automatic opdec_pkg::decoded_t modrm_fill(input opdec_pkg::decoded_t d, input logic [7:0] opc,
                                                      input logic [7:0] m);
        opdec_pkg::decoded_t r;
        logic mem;
        logic [7:0] c;
        r = d;
        mem = (m[7:6] != opdec_pkg::MOD_REGISTER);
        r.is_memory = mem;
        r.reg_field = m[5:3];
        r.rm_field = m[2:0];
        r.shift_op_field = opdec_pkg::shift_op_field_t'(m[5:3]);
        c = opdec_pkg::CYC_ILLEGAL;
        if (opc[7:1] == 7'b1111011) begin
            case (m[5:3])
                opdec_pkg::GRP3_TEST: begin
                    r.op = opdec_pkg::OP_TEST;
                    r.writes_result = 1'b0;
                    c = pick(mem, opdec_pkg::CYC_LOGIC_MEM, opdec_pkg::CYC_TEST_IMM_REG);
                end
                opdec_pkg::GRP3_INVERT: begin
                    r.op = opdec_pkg::OP_INVERT;
                    c = pick(mem, opdec_pkg::CYC_LOGIC_MEM, opdec_pkg::CYC_LOGIC_REG);
                end
                opdec_pkg::GRP3_SMUL: begin
                    r.op = opdec_pkg::OP_SIGNED_MULTIPLY;
                    c = mem ? pick(d.word, opdec_pkg::CYC_SMUL_MW_MIN, opdec_pkg::CYC_SMUL_MB_MIN)
                            : pick(d.word, opdec_pkg::CYC_SMUL_RW_MIN, opdec_pkg::CYC_SMUL_RB_MIN);
                    r.cycles_max = mem ? pick(d.word, opdec_pkg::CYC_SMUL_MW_MAX, opdec_pkg::CYC_SMUL_MB_MAX)
                                       : pick(d.word, opdec_pkg::CYC_SMUL_RW_MAX, opdec_pkg::CYC_SMUL_RB_MAX);
                end
                opdec_pkg::GRP3_UDIV: begin
                    r.op = opdec_pkg::OP_UNSIGNED_DIVIDE;
                    c = mem ? pick(d.word, opdec_pkg::CYC_UDIV_MW, opdec_pkg::CYC_UDIV_MB)
                            : pick(d.word, opdec_pkg::CYC_UDIV_RW, opdec_pkg::CYC_UDIV_RB);
                end
                opdec_pkg::GRP3_SDIV: begin
                    r.op = opdec_pkg::OP_SIGNED_QUOTIENT;
                    c = mem ? pick(d.word, opdec_pkg::CYC_SDIV_MW_MIN, opdec_pkg::CYC_SDIV_MB_MIN)
                            : pick(d.word, opdec_pkg::CYC_SDIV_RW_MIN, opdec_pkg::CYC_SDIV_RB_MIN);
                    r.cycles_max = mem ? pick(d.word, opdec_pkg::CYC_SDIV_MW_MAX, opdec_pkg::CYC_SDIV_MB_MAX)
                                       : pick(d.word, opdec_pkg::CYC_SDIV_RW_MAX, opdec_pkg::CYC_SDIV_RB_MAX);
                end
                default: r.op = opdec_pkg::OP_ILLEGAL;
            endcase
        end else if (opc[7:2] == 6'b100000) begin
            case (m[5:3])
                opdec_pkg::GRP1_AND: r.op = opdec_pkg::OP_AND;
                opdec_pkg::GRP1_OR:  r.op = opdec_pkg::OP_OR;
                opdec_pkg::GRP1_XOR: r.op = opdec_pkg::OP_XOR;
                default:             r.op = opdec_pkg::OP_ILLEGAL;
            endcase
            c = pick(mem, opdec_pkg::CYC_LOGIC_IMM_M, opdec_pkg::CYC_TEST_IMM_REG);
        end else if (opc[7:1] == 7'b1101000) begin
            r.op = opdec_pkg::OP_SHIFT_BY_ONE;
            c = pick(mem, opdec_pkg::CYC_SHIFT1_MEM, opdec_pkg::CYC_SHIFT1_REG);
        end else if (opc[7:1] == 7'b1100000) begin
            r.op = opdec_pkg::OP_SHIFT_BY_COUNT;
            c = pick(mem, opdec_pkg::CYC_SHIFTN_MEM, opdec_pkg::CYC_SHIFTN_REG);
        end else if (opc[7:2] == 6'b011010 && opc[0]) begin
            c = pick(mem, opdec_pkg::CYC_SMULI_M_MIN, opdec_pkg::CYC_SMULI_R_MIN);
            r.cycles_max = pick(mem, opdec_pkg::CYC_SMULI_M_MAX, opdec_pkg::CYC_SMULI_R_MAX);
        end else begin
            c = pick(mem, opdec_pkg::CYC_LOGIC_MEM, opdec_pkg::CYC_LOGIC_REG);
        end
        if (opc[7:1] == 7'b1101000 || opc[7:1] == 7'b1100000) begin
            if (m[5:3] == 3'h6) r.op = opdec_pkg::OP_ILLEGAL;
        end
        r.cycles_min = c;
        if (r.op != opdec_pkg::OP_SIGNED_MULTIPLY && r.op != opdec_pkg::OP_SIGNED_QUOTIENT &&
            r.op != opdec_pkg::OP_SIGNED_MULTIPLY_IMM) r.cycles_max = c;
        modrm_fill = r;
    endfunction

    always_comb begin
        opdec_pkg::decoded_t d;
        d = cur_reg;
        state_next = state_reg;
        cur_next = cur_reg;
        out_next = out_reg;
        out_valid_next = 1'b0;
        imm_word_next = imm_word_reg;
        need_imm_next = need_imm_reg;
        opc_next = opc_reg;
        if (i_byte_valid) begin
            case (state_reg)
                opdec_pkg::ST_OPCODE: begin
                    d = '0;
                    d.op = opdec_pkg::OP_ILLEGAL;
                    d.word = i_byte[0];
                    d.reg_is_dest = i_byte[1];
                    d.writes_result = 1'b1;
                    opc_next = i_byte;
                    need_imm_next = 1'b0;
                    imm_word_next = i_byte[0];
                    state_next = opdec_pkg::ST_MODRM;
                    if (i_byte[7:1] == 7'b1111011 || i_byte[7:1] == 7'b1101000 || i_byte[7:1] == 7'b1100000) begin
                        need_imm_next = (i_byte[7:1] == 7'b1100000);
                        imm_word_next = 1'b0;
                        d.reg_is_dest = 1'b0;
                    end else if (i_byte[7:2] == 6'b011010 && i_byte[0]) begin
                        d.op = opdec_pkg::OP_SIGNED_MULTIPLY_IMM;
                        d.word = 1'b1;
                        d.reg_is_dest = 1'b1;
                        need_imm_next = 1'b1;
                        imm_word_next = ~i_byte[1];
                    end else if (i_byte[7:2] == 6'b100000) begin
                        need_imm_next = 1'b1;
                        imm_word_next = i_byte[1:0] == 2'b01;
                        d.reg_is_dest = 1'b0;
                    end else if (i_byte[7:2] == 6'b001000) begin
                        d.op = opdec_pkg::OP_AND;
                    end else if (i_byte[7:2] == 6'b000010) begin
                        d.op = opdec_pkg::OP_OR;
                    end else if (i_byte[7:2] == 6'b001100) begin
                        d.op = opdec_pkg::OP_XOR;
                    end else if (i_byte[7:1] == 7'b1000010) begin
                        d.op = opdec_pkg::OP_TEST;
                        d.writes_result = 1'b0;
                    end else if (i_byte[7:1] == 7'b0010010 || i_byte[7:1] == 7'b0000110 ||
                                 i_byte[7:1] == 7'b0011010 || i_byte[7:1] == 7'b1010100) begin
                        case (i_byte[7:4])
                            4'h2:    d.op = i_byte[4] ? opdec_pkg::OP_XOR : opdec_pkg::OP_AND;
                            4'h3:    d.op = opdec_pkg::OP_XOR;
                            4'h0:    d.op = opdec_pkg::OP_OR;
                            default: begin
                                d.op = opdec_pkg::OP_TEST;
                                d.writes_result = 1'b0;
                            end
                        endcase
                        d.cycles_min = pick(i_byte[0], opdec_pkg::CYC_ACC_WORD, opdec_pkg::CYC_ACC_BYTE);
                        d.cycles_max = d.cycles_min;
                        state_next = opdec_pkg::ST_IMM_LO;
                    end else if (i_byte[7:1] == 7'b1101010) begin
                        d.op = i_byte[0] ? opdec_pkg::OP_BCD_ADJUST_BEFORE_QUOTIENT
                                         : opdec_pkg::OP_BCD_ADJUST_AFTER_PRODUCT;
                        d.cycles_min = pick(i_byte[0], opdec_pkg::CYC_BCD_QUOTIENT,
                                            opdec_pkg::CYC_BCD_PRODUCT);
                        d.cycles_max = d.cycles_min;
                        state_next = opdec_pkg::ST_BASE;
                    end else if (i_byte[7:1] == 7'b1001100) begin
                        d.op = i_byte[0] ? opdec_pkg::OP_SIGN_EXTEND_WORD_TO_PAIR
                                         : opdec_pkg::OP_SIGN_EXTEND_BYTE;
                        d.cycles_min = pick(i_byte[0], opdec_pkg::CYC_SEXT_WORD, opdec_pkg::CYC_SEXT_BYTE);
                        d.cycles_max = d.cycles_min;
                        out_next = d;
                        out_valid_next = 1'b1;
                        state_next = opdec_pkg::ST_OPCODE;
                    end else begin
                        out_next = d;
                        out_valid_next = 1'b1;
                        state_next = opdec_pkg::ST_OPCODE;
                    end
                    cur_next = d;
                end
                opdec_pkg::ST_MODRM: begin
                    d = modrm_fill(cur_reg, opc_reg, i_byte);
                    if (opc_reg[7:1] == 7'b1111011 && i_byte[5:3] == opdec_pkg::GRP3_TEST)
                        need_imm_next = 1'b1;
                    if (opc_reg[7:1] == 7'b1111011 && i_byte[5:3] == opdec_pkg::GRP3_TEST)
                        imm_word_next = cur_reg.word;
                    cur_next = d;
                    if (need_imm_next || (opc_reg[7:1] == 7'b1111011 && i_byte[5:3] == opdec_pkg::GRP3_TEST)) begin
                        state_next = opdec_pkg::ST_IMM_LO;
                    end else begin
                        out_next = d;
                        out_valid_next = 1'b1;
                        state_next = opdec_pkg::ST_OPCODE;
                    end
                end
                opdec_pkg::ST_IMM_LO: begin
                    d.immediate = {{8{i_byte[7]}}, i_byte};
                    if (cur_reg.op == opdec_pkg::OP_SHIFT_BY_COUNT) begin
                        d.immediate = {8'h00, i_byte};
                        d.cycles_min = 8'(cur_reg.cycles_min + i_byte);
                        d.cycles_max = d.cycles_min;
                    end
                    cur_next = d;
                    if (imm_word_reg) begin
                        state_next = opdec_pkg::ST_IMM_HI;
                    end else begin
                        out_next = d;
                        out_valid_next = 1'b1;
                        state_next = opdec_pkg::ST_OPCODE;
                    end
                end
                opdec_pkg::ST_IMM_HI: begin
                    d.immediate[15:8] = i_byte;
                    cur_next = d;
                    out_next = d;
                    out_valid_next = 1'b1;
                    state_next = opdec_pkg::ST_OPCODE;
                end
                opdec_pkg::ST_BASE: begin
                    if (i_byte != opdec_pkg::BCD_BASE_BYTE) d.op = opdec_pkg::OP_ILLEGAL;
                    out_next = d;
                    out_valid_next = 1'b1;
                    state_next = opdec_pkg::ST_OPCODE;
                end
                default: state_next = opdec_pkg::ST_OPCODE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg     <= opdec_pkg::ST_OPCODE;
            cur_reg       <= '0;
            out_reg       <= '0;
            out_valid_reg <= 1'b0;
            imm_word_reg  <= 1'b0;
            need_imm_reg  <= 1'b0;
            opc_reg       <= 8'h00;
        end else if (i_ce) begin
            state_reg     <= state_next;
            cur_reg       <= cur_next;
            out_reg       <= out_next;
            out_valid_reg <= out_valid_next;
            imm_word_reg  <= imm_word_next;
            need_imm_reg  <= need_imm_next;
            opc_reg       <= opc_next;
        end
    end

    assign o_dec_valid = out_valid_reg;
    assign o_dec       = out_reg;

    AST_SEXT_BYTE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && i_byte_valid && state_reg == opdec_pkg::ST_OPCODE && i_byte == 8'h98) |=>
        (o_dec_valid && o_dec.op == opdec_pkg::OP_SIGN_EXTEND_BYTE && o_dec.cycles_min == 8'd2))
        else $error("sign extend byte decode wrong");
    AST_SEXT_WORD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_ce && i_byte_valid && state_reg == opdec_pkg::ST_OPCODE && i_byte == 8'h99) |=>
        (o_dec_valid && o_dec.cycles_min == 8'd4))
        else $error("sign extend word decode wrong");
    AST_TEST_NO_WRITE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && o_dec.op == opdec_pkg::OP_TEST) |-> !o_dec.writes_result)
        else $error("test writes a result");
    AST_SMUL_RANGE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && o_dec.op == opdec_pkg::OP_SIGNED_MULTIPLY && !o_dec.is_memory && !o_dec.word)
        |-> o_dec.cycles_min == 8'd25)
        else $error("signed multiply byte cycles wrong");
    AST_SDIV_RANGE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && o_dec.op == opdec_pkg::OP_SIGNED_QUOTIENT && o_dec.is_memory && o_dec.word)
        |-> o_dec.cycles_min == 8'd59)
        else $error("signed divide memory word cycles wrong");
    AST_UDIV_RB: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && o_dec.op == opdec_pkg::OP_UNSIGNED_DIVIDE && !o_dec.is_memory && !o_dec.word)
        |-> o_dec.cycles_min == 8'd29)
        else $error("unsigned divide byte cycles wrong");
    AST_LOGIC_MEM: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && o_dec.op == opdec_pkg::OP_INVERT) |-> o_dec.cycles_min == (o_dec.is_memory ? 8'd10 : 8'd3))
        else $error("invert cycles wrong");
    AST_BCD_PRODUCT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && o_dec.op == opdec_pkg::OP_BCD_ADJUST_AFTER_PRODUCT) |-> o_dec.cycles_min == 8'd19)
        else $error("adjust after product cycles wrong");
    AST_LOGIC_WRITES: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (o_dec_valid && (o_dec.op == opdec_pkg::OP_AND || o_dec.op == opdec_pkg::OP_OR ||
                         o_dec.op == opdec_pkg::OP_XOR)) |-> o_dec.writes_result)
        else $error("logic op drops its result");
endmodule
`default_nettype wire

// ### hdl/opdec_pkg.sv
// Summary of operation
// - F6/F7 op 101 is signed multiply
// - 011010s1 modrm imm is immediate signed multiply
// - F6/F7 op 111 is signed divide
// - D4 0A is adjust after product, 19
// - D5 0A is adjust before quotient, 15
// - 98 sign extends byte, 2 cycles
// - 99 sign extends word to pair, 4
// - D0/D1 modrm is shift by one
// - C0/C1 modrm count shifts, 5/17 plus n
// - AND OR XOR reg forms, 3/10
// - 84/85 test reg with modrm, 3/10
// - F6/F7 op 000 test immediate, 4/10
// - A8/A9 test accumulator immediate, 3/4
`default_nettype none
package opdec_pkg;
    typedef enum logic [4:0] {
        OP_NONE                       = 5'h00,
        OP_SIGNED_MULTIPLY            = 5'h01,
        OP_SIGNED_MULTIPLY_IMM        = 5'h02,
        OP_UNSIGNED_DIVIDE            = 5'h03,
        OP_SIGNED_QUOTIENT            = 5'h04,
        OP_BCD_ADJUST_AFTER_PRODUCT   = 5'h05,
        OP_BCD_ADJUST_BEFORE_QUOTIENT = 5'h06,
        OP_SIGN_EXTEND_BYTE           = 5'h07,
        OP_SIGN_EXTEND_WORD_TO_PAIR   = 5'h08,
        OP_SHIFT_BY_ONE               = 5'h09,
        OP_SHIFT_BY_COUNT             = 5'h0a,
        OP_AND                        = 5'h0b,
        OP_OR                         = 5'h0c,
        OP_XOR                        = 5'h0d,
        OP_TEST                       = 5'h0e,
        OP_INVERT                     = 5'h0f,
        OP_ILLEGAL                    = 5'h1f
    } op_t;

    typedef enum logic [2:0] {
        rotate_left                = 3'h0,
        rotate_right               = 3'h1,
        rotate_through_carry_left  = 3'h2,
        rotate_through_carry_right = 3'h3,
        shift_left                 = 3'h4,
        logical_shift_right        = 3'h5,
        shift_reserved             = 3'h6,
        arithmetic_shift_right     = 3'h7
    } shift_op_field_t;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'h0,
        ST_MODRM  = 3'h1,
        ST_IMM_LO = 3'h2,
        ST_IMM_HI = 3'h3,
        ST_COUNT  = 3'h4,
        ST_BASE   = 3'h5
    } state_t;

    typedef struct packed {
        op_t             op;
        logic            word;
        logic            reg_is_dest;
        logic            writes_result;
        logic            is_memory;
        shift_op_field_t shift_op_field;
        logic [2:0]      reg_field;
        logic [2:0]      rm_field;
        logic [15:0]     immediate;
        logic [7:0]      cycles_min;
        logic [7:0]      cycles_max;
    } decoded_t;

    localparam logic [7:0] BCD_BASE_BYTE = 8'h0a;
    localparam logic [2:0] GRP3_TEST     = 3'h0;
    localparam logic [2:0] GRP3_INVERT   = 3'h2;
    localparam logic [2:0] GRP3_SMUL     = 3'h5;
    localparam logic [2:0] GRP3_UDIV     = 3'h6;
    localparam logic [2:0] GRP3_SDIV     = 3'h7;
    localparam logic [2:0] GRP1_AND      = 3'h4;
    localparam logic [2:0] GRP1_OR       = 3'h1;
    localparam logic [2:0] GRP1_XOR      = 3'h6;
    localparam logic [1:0] MOD_REGISTER  = 2'h3;
    // Cycle figures
    localparam logic [7:0] CYC_SMUL_RB_MIN  = 8'd25;
    localparam logic [7:0] CYC_SMUL_RB_MAX  = 8'd28;
    localparam logic [7:0] CYC_SMUL_RW_MIN  = 8'd34;
    localparam logic [7:0] CYC_SMUL_RW_MAX  = 8'd37;
    localparam logic [7:0] CYC_SMUL_MB_MIN  = 8'd31;
    localparam logic [7:0] CYC_SMUL_MB_MAX  = 8'd34;
    localparam logic [7:0] CYC_SMUL_MW_MIN  = 8'd40;
    localparam logic [7:0] CYC_SMUL_MW_MAX  = 8'd43;
    localparam logic [7:0] CYC_SMULI_R_MIN  = 8'd22;
    localparam logic [7:0] CYC_SMULI_R_MAX  = 8'd25;
    localparam logic [7:0] CYC_SMULI_M_MIN  = 8'd29;
    localparam logic [7:0] CYC_SMULI_M_MAX  = 8'd32;
    localparam logic [7:0] CYC_UDIV_RB      = 8'd29;
    localparam logic [7:0] CYC_UDIV_RW      = 8'd38;
    localparam logic [7:0] CYC_UDIV_MB      = 8'd35;
    localparam logic [7:0] CYC_UDIV_MW      = 8'd44;
    localparam logic [7:0] CYC_SDIV_RB_MIN  = 8'd44;
    localparam logic [7:0] CYC_SDIV_RB_MAX  = 8'd52;
    localparam logic [7:0] CYC_SDIV_RW_MIN  = 8'd53;
    localparam logic [7:0] CYC_SDIV_RW_MAX  = 8'd61;
    localparam logic [7:0] CYC_SDIV_MB_MIN  = 8'd50;
    localparam logic [7:0] CYC_SDIV_MB_MAX  = 8'd58;
    localparam logic [7:0] CYC_SDIV_MW_MIN  = 8'd59;
    localparam logic [7:0] CYC_SDIV_MW_MAX  = 8'd67;
    localparam logic [7:0] CYC_BCD_PRODUCT  = 8'd19;
    localparam logic [7:0] CYC_BCD_QUOTIENT = 8'd15;
    localparam logic [7:0] CYC_SEXT_BYTE    = 8'd2;
    localparam logic [7:0] CYC_SEXT_WORD    = 8'd4;
    localparam logic [7:0] CYC_SHIFT1_REG   = 8'd2;
    localparam logic [7:0] CYC_SHIFT1_MEM   = 8'd15;
    localparam logic [7:0] CYC_SHIFTN_REG   = 8'd5;
    localparam logic [7:0] CYC_SHIFTN_MEM   = 8'd17;
    localparam logic [7:0] CYC_LOGIC_REG    = 8'd3;
    localparam logic [7:0] CYC_LOGIC_MEM    = 8'd10;
    localparam logic [7:0] CYC_LOGIC_IMM_M  = 8'd16;
    localparam logic [7:0] CYC_TEST_IMM_REG = 8'd4;
    localparam logic [7:0] CYC_ACC_BYTE     = 8'd3;
    localparam logic [7:0] CYC_ACC_WORD     = 8'd4;
    localparam logic [7:0] CYC_ILLEGAL      = 8'd0;
endpackage
`default_nettype wire

// ### bench/prog_mem_model.sv
`default_nettype none
module prog_mem_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // Slow fetch request
    input  wire logic       i_stall,
    // Decoder clock enable
    input  wire logic       i_ce,
    // Instruction bytes
    output var  logic       o_valid,
    output var  logic [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    initial begin
        o_valid = 1'b0;
        o_byte  = 8'h00;
    end
    // Idle line flips every cycle so a stale byte never looks valid
    always @(posedge i_clk) begin
        if (i_arst_n && o_valid && !i_ce) begin
            o_valid <= 1'b1;
        end else if (i_arst_n && !i_stall && q.size() > 0) begin
            o_valid <= 1'b1;
            o_byte  <= q.pop_front();
        end else begin
            o_valid <= 1'b0;
            o_byte  <= ~o_byte;
        end
    end
endmodule
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int op; int w; int cmin; int cmax; int imm; int f; int mr; int rd;} exp_t;
    logic                i_clk = 1'b0;
    logic                i_arst_n = 1'b0;
    logic                stall = 1'b0;
    logic                ce = 1'b1;
    logic                bvalid;
    logic [7:0]          bbyte;
    logic                dvalid;
    opdec_pkg::decoded_t dec;
    logic [31:0]         lfsr = 32'h2de8;
    int                  err_count = 0;
    int                  total_checks = 0;
    exp_t                eq[$];
    exp_t                e;
    always #2 i_clk = ~i_clk;
    prog_mem_model mem_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_stall(stall), .i_ce(ce), .o_valid(bvalid),
        .o_byte(bbyte));
    muldiv_logic_opcode_decode dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce), .i_byte_valid(bvalid),
        .i_byte(bbyte), .o_dec_valid(dvalid), .o_dec(dec));
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [15:0] got, input int exp);
        if (exp < 0) return;
        total_checks++;
        if (got !== 16'(exp)) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, 16'(exp));
        end
    endtask
    // Queue bytes (first byte lowest) and the decode they must give
    task automatic ins(input logic [31:0] b, input int n, input int op, input int w, input int cmin, input int cmax,
                       input int imm, input int f);
        int mr;
        int rd;
        mr = (n > 1 && !(b[7:0] inside {8'h24, 8'h25, 8'h0c, 8'h0d, 8'h34, 8'h35, 8'ha8, 8'ha9, 8'hd4, 8'hd5}))
             ? int'(b[15:8]) : -1;
        rd = (b[7:2] inside {6'b001000, 6'b000010, 6'b001100}) ? int'(b[1]) : -1;
        for (int k = 0; k < n; k++) mem_u.push(b[8*k +: 8]);
        eq.push_back('{op, w, cmin, cmax, imm, f, mr, rd});
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge i_clk) begin
        stall <= lfsr[0] & lfsr[3];
        ce    <= ~(lfsr[2] & lfsr[7]);
        lfsr  <= lfsr_next(lfsr);
        if (dvalid !== 1'b0 && ce && i_arst_n) begin
            if (eq.size() == 0) chk(16'h1, 0);
            else begin
                e = eq.pop_front();
                chk(16'(dec.op), e.op);
                chk(16'(dec.word), e.w);
                chk(16'(dec.cycles_min), e.cmin);
                chk(16'(dec.cycles_max), e.cmax);
                chk(dec.immediate, e.imm);
                chk(16'(dec.shift_op_field), e.f);
                chk(16'(dec.reg_is_dest), e.rd);
                if (e.mr >= 0) begin
                    chk(16'(dec.is_memory), int'(e.mr[7:6] != 2'h3));
                    chk(16'(dec.reg_field), (e.mr >> 3) & 7);
                    chk(16'(dec.rm_field), e.mr & 7);
                end
            end
        end
    end
    initial begin
        logic [31:0] r;
        r = 32'h2de8;
        ins(32'h98, 1, 5'h07, -1, 2, 2, -1, -1);
        ins(32'h99, 1, 5'h08, -1, 4, 4, -1, -1);
        ins(32'h0ad4, 2, 5'h05, -1, 19, 19, -1, -1);
        ins(32'h0ad5, 2, 5'h06, -1, 15, 15, -1, -1);
        ins(32'h0bd4, 2, 5'h1f, -1, -1, -1, -1, -1);
        ins(32'he8f6, 2, 5'h01, 0, 25, 28, -1, -1);
        ins(32'h28f7, 2, 5'h01, 1, 40, 43, -1, -1);
        ins(32'h1234c069, 4, 5'h02, 1, 22, 25, 'h1234, -1);
        ins(32'h80006b, 3, 5'h02, 1, 29, 32, 'hff80, -1);
        ins(32'hf0f6, 2, 5'h03, 0, 29, 29, -1, -1);
        ins(32'h30f7, 2, 5'h03, 1, 44, 44, -1, -1);
        ins(32'hf8f6, 2, 5'h04, 0, 44, 52, -1, -1);
        ins(32'h38f7, 2, 5'h04, 1, 59, 67, -1, -1);
        ins(32'hc120, 2, 5'h0b, 0, 3, 3, -1, -1);
        ins(32'h0709, 2, 5'h0c, 1, 10, 10, -1, -1);
        ins(32'hc031, 2, 5'h0d, 1, 3, 3, -1, -1);
        ins(32'hc085, 2, 5'h0e, 1, 3, 3, -1, -1);
        ins(32'h55c0f6, 3, 5'h0e, 0, 4, 4, 'h0055, -1);
        ins(32'h123400f7, 4, 5'h0e, 1, 10, 10, 'h1234, -1);
        ins(32'h7fa8, 2, 5'h0e, 0, 3, 3, 'h007f, -1);
        ins(32'h1234a9, 3, 5'h0e, 1, 4, 4, 'h1234, -1);
        ins(32'hd0f6, 2, 5'h0f, 0, 3, 3, -1, -1);
        ins(32'hc8f6, 2, 5'h1f, -1, -1, -1, -1, -1);
        ins(32'h7fe080, 3, 5'h0b, 0, 4, 4, 'h007f, -1);
        ins(32'h1234c881, 4, 5'h0c, 1, 4, 4, 'h1234, -1);
        ins(32'h80f083, 3, 5'h0d, 1, 4, 4, 'hff80, -1);
        ins(32'h1224, 2, 5'h0b, 0, 3, 3, 'h0012, -1);
        ins(32'h12340d, 3, 5'h0c, 1, 4, 4, 'h1234, -1);
        ins(32'h5534, 2, 5'h0d, 0, 3, 3, 'h0055, -1);
        ins(32'he8f7, 2, 5'h01, 1, 34, 37, -1, -1);
        ins(32'h28f6, 2, 5'h01, 0, 31, 34, -1, -1);
        ins(32'h0722, 2, 5'h0b, 0, 10, 10, -1, -1);
        ins(32'h12342081, 4, 5'h0b, 1, 16, 16, 'h1234, -1);
        ins(32'h0520c1, 3, 5'h0a, 1, 22, 22, -1, 4);
        for (int f = 0; f < 8; f++) begin
            r = lfsr_next(r);
            ins({16'h0, 8'hc0 | 8'(f << 3), 8'hd1}, 2, f == 6 ? 5'h1f : 5'h09, f == 6 ? -1 : 1, f == 6 ? -1 : 2,
                f == 6 ? -1 : 2, -1, f == 6 ? -1 : f);
            if (f != 6) ins({8'h0, r[7:0] & 8'h3f, 8'hc0 | 8'(f << 3), 8'hc0}, 3, 5'h0a, 0, 5 + int'(r[5:0]),
                5 + int'(r[5:0]), -1, f);
        end
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (int k = 0; k < 5000 && eq.size() > 0; k++) @(posedge i_clk);
        if (eq.size() > 0) err_count++;
        summarize();
    end
endmodule
`default_nettype wire
